// ==== core/sbc_commutator.sv ====
/*
  Sensorless three-phase commutation controller: start and stop from the PWM
  input, forced startup stepping, back-EMF commutation with lead angle and
  optional lap overlap, and six turn-on outputs toward an external bridge.
  Assumes every input is synchronous to i_core_clk and that the selection
  pins are static while the motor runs.
*/
`timescale 1ns/1ps

module sbc_commutator
  import sbc_pkg::*;
#(
  parameter int FORCED_STEP_XT = SBC_FORCED_STEP_XT,  // resonator ticks a step
  parameter int STOP_GAP_XT = SBC_STOP_GAP_XT         // ticks without on pulse
)(
  input wire logic i_core_clk,          // 250 MHz core clock
  input wire logic i_reset,             // async reset, active high
  input wire logic i_pwm_n,             // PWM input, low-active
  input wire logic i_wave,              // majority back-EMF position input
  input wire logic i_overcurrent_in,    // overcurrent input, high is fault
  input wire logic i_advance_sel_lo,    // lead angle select, low bit
  input wire logic i_advance_sel_hi,    // lead angle select, high bit
  input wire logic i_direction_select,  // 1 reverse, 0 forward
  input wire logic i_out_form_sel,      // 0 upper chop, 1 alternate chop
  input wire logic i_lap_sel,           // 1 plain 120 degree, 0 lap mode
  output logic o_u_high_side_on_n,      // U high side, low is on
  output logic o_u_low_side_on,         // U low side, high is on
  output logic o_v_high_side_on_n,      // V high side, low is on
  output logic o_v_low_side_on,         // V low side, high is on
  output logic o_w_high_side_on_n,      // W high side, low is on
  output logic o_w_low_side_on,         // W low side, high is on
  output logic o_forced,                // startup stepping active
  output logic o_running                // back-EMF stepping active
);

  typedef struct packed {
    sbc_mode_t mode;
    logic [SBC_DIV_W-1:0] div;
    logic [SBC_XT_W-1:0] xt_cnt;
    logic [SBC_XT_W-1:0] gap;
    logic [SBC_PULSE_W-1:0] pulses;
    logic [1:0] good;
    logic [SBC_STEP_W-1:0] step;
    logic [SBC_STEP_W-1:0] lap_step;
    logic [SBC_TMR_W-1:0] tmr;
    logic [SBC_TMR_W-1:0] delay;
    logic pending;
    logic [SBC_TMR_W-1:0] lap_cnt;
  } sbc_state_t;

  sbc_state_t st_reg;
  sbc_state_t st_next;

  logic on_start;
  logic pos_change;
  logic oc_block;
  logic xt_tick;
  logic [1:0] lead;
  logic [SBC_TMR_W-1:0] zc_delay;
  logic [SBC_TMR_W-1:0] lap_time;
  logic [2:0] hi_n;
  logic [2:0] lo_on;

  localparam logic [SBC_DIV_W-1:0] DIV_LAST = SBC_DIV_W'(SBC_XT_DIV - 1);
  localparam logic [SBC_XT_W-1:0] STEP_XT = SBC_XT_W'(FORCED_STEP_XT);
  localparam logic [SBC_XT_W-1:0] HALF_STEP_XT = SBC_XT_W'(FORCED_STEP_XT / 2);
  localparam logic [SBC_XT_W-1:0] STOP_XT = SBC_XT_W'(STOP_GAP_XT);
  localparam logic [SBC_XT_W-1:0] START_XT = SBC_XT_W'(SBC_START_GAP_XT);
  localparam logic [SBC_PULSE_W-1:0] START_N = SBC_PULSE_W'(SBC_START_PULSES);
  localparam logic [1:0] GOOD_N = 2'(SBC_GOOD_EDGES);
  localparam logic [SBC_TMR_W-1:0] TMR_MAX = {SBC_TMR_W{1'b1}};

  // ----------------------------------------------------------------
  // Input sensing
  // ----------------------------------------------------------------
  sbc_pwm_sense u_sense (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_pwm_n(i_pwm_n),
    .i_wave(i_wave),
    .i_overcurrent_in(i_overcurrent_in),
    .o_on_start(on_start),
    .o_pwm_rise(),
    .o_pos_change(pos_change),
    .o_oc_block(oc_block)
  );

  // ----------------------------------------------------------------
  // Lead angle and lap timing
  // ----------------------------------------------------------------
  // Lead is zero during startup unless both selects are high
  always_comb begin
    lead = {i_advance_sel_hi, i_advance_sel_lo};
    if (st_reg.mode != SBC_RUN && lead != SBC_LEAD_30) begin
      lead = SBC_LEAD_0;
    end
  end

  // Zero crossing sits 30 degrees before the ideal step; the measured
  // interval between crossings is 60 degrees, so shifts give the fractions.
  always_comb begin
    case (lead)
      SBC_LEAD_0: begin
        zc_delay = st_reg.tmr >> 1;
        lap_time = st_reg.tmr >> 3;
      end
      SBC_LEAD_7P5: begin
        zc_delay = (st_reg.tmr >> 2) + (st_reg.tmr >> 3);
        lap_time = st_reg.tmr >> 4;
      end
      SBC_LEAD_15: begin
        zc_delay = st_reg.tmr >> 2;
        lap_time = st_reg.tmr >> 5;
      end
      default: begin
        zc_delay = '0;
        lap_time = st_reg.tmr >> 6;
      end
    endcase
  end

  assign xt_tick = (st_reg.div == DIV_LAST);

  // ----------------------------------------------------------------
  // Mode and step control
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.div = xt_tick ? '0 : st_reg.div + 1'b1;
    if (st_reg.tmr != TMR_MAX) begin
      st_next.tmr = st_reg.tmr + 1'b1;
    end
    if (st_reg.lap_cnt != '0) begin
      st_next.lap_cnt = st_reg.lap_cnt - 1'b1;
    end
    // Gap counts resonator ticks since the last on pulse
    if (on_start) begin
      st_next.gap = '0;
      if (st_reg.gap <= START_XT) begin
        if (st_reg.pulses != START_N) begin
          st_next.pulses = st_reg.pulses + 1'b1;
        end
      end else begin
        st_next.pulses = SBC_PULSE_W'(1);
      end
    end else if (xt_tick && st_reg.gap != STOP_XT) begin
      st_next.gap = st_reg.gap + 1'b1;
    end

    case (st_reg.mode)
      SBC_IDLE: begin
        st_next.lap_cnt = '0;
        st_next.pending = 1'b0;
        if (st_next.pulses == START_N) begin
          st_next.mode = SBC_FORCED;
          st_next.step = SBC_STEP_FIRST;
          st_next.good = '0;
          st_next.xt_cnt = (lead == SBC_LEAD_30) ? HALF_STEP_XT : '0;
        end
      end
      SBC_FORCED: begin
        // Steps advance on the resonator count alone
        if (xt_tick) begin
          st_next.xt_cnt = st_reg.xt_cnt + 1'b1;
          if (st_next.xt_cnt >= STEP_XT) begin
            st_next.xt_cnt = '0;
            st_next.step = sbc_next_step(st_reg.step, i_direction_select);
          end
        end
        if (pos_change) begin
          st_next.tmr = '0;
          st_next.good = st_reg.good + 1'b1;
          if (st_next.good == GOOD_N) begin
            st_next.mode = SBC_RUN;
            // The confirming crossing must commute too, or a slow rotor
            // that only moves when driven never gives another crossing
            st_next.delay = zc_delay;
            st_next.pending = 1'b1;
          end
        end
      end
      SBC_RUN: begin
        if (pos_change) begin
          st_next.tmr = '0;
          st_next.delay = zc_delay;
          st_next.pending = 1'b1;
        end else if (st_reg.pending) begin
          if (st_reg.delay == '0) begin
            st_next.pending = 1'b0;
            st_next.lap_step = st_reg.step;
            st_next.step = sbc_next_step(st_reg.step, i_direction_select);
            st_next.lap_cnt = i_lap_sel ? '0 : lap_time;
          end else begin
            st_next.delay = st_reg.delay - 1'b1;
          end
        end
      end
      default: begin
        st_next.mode = SBC_IDLE;
      end
    endcase

    // No on pulse for the stop gap means zero duty
    if (st_reg.mode != SBC_IDLE && st_reg.gap == STOP_XT) begin
      st_next.mode = SBC_IDLE;
      st_next.pulses = '0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '{mode: SBC_IDLE, div: '0, xt_cnt: '0, gap: '0, pulses: '0,
                  good: '0, step: SBC_STEP_FIRST, lap_step: SBC_STEP_FIRST,
                  tmr: '0, delay: '0, pending: 1'b0, lap_cnt: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Output forming
  // ----------------------------------------------------------------
  // Chopping follows the PWM on level; the overcurrent latch cuts it
  sbc_drive_out u_drive (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_enable(st_reg.mode != SBC_IDLE),
    .i_step(st_reg.step),
    .i_lap_step(st_reg.lap_step),
    .i_lap_active(st_reg.lap_cnt != '0),
    .i_chop_on(~i_pwm_n & ~oc_block),
    .i_out_form_sel(i_out_form_sel),
    .o_high_side_on_n(hi_n),
    .o_low_side_on(lo_on)
  );

  assign o_u_high_side_on_n = hi_n[0];
  assign o_v_high_side_on_n = hi_n[1];
  assign o_w_high_side_on_n = hi_n[2];
  assign o_u_low_side_on = lo_on[0];
  assign o_v_low_side_on = lo_on[1];
  assign o_w_low_side_on = lo_on[2];
  assign o_forced = (st_reg.mode == SBC_FORCED);
  assign o_running = (st_reg.mode == SBC_RUN);

endmodule

// ==== shared/sbc_pkg.sv ====
/*
  Constants, state encodings and commutation tables shared by the
  sensorless commutator and its two helper modules.
  Assumes a single 250 MHz core clock; the resonator is modelled as an enable.
*/
package sbc_pkg;

  // ----------------------------------------------------------------
  // Clock and resonator
  // ----------------------------------------------------------------
  localparam int SBC_CORE_MHZ = 250;
  localparam int SBC_XT_MHZ = 4;
  localparam int SBC_XT_DIV = SBC_CORE_MHZ / SBC_XT_MHZ;
  localparam int SBC_DIV_W = 8;

  // Startup rate: fxt / (6 * 2^(bits + 3)) per turn, six steps a turn
  localparam int SBC_CNT_BITS = 14;
  localparam int SBC_XT_EXP = SBC_CNT_BITS + 3;
  localparam int SBC_FORCED_STEP_XT = 1 << SBC_XT_EXP;
  localparam int SBC_XT_W = SBC_XT_EXP + 2;

  // ----------------------------------------------------------------
  // Start and stop detection; gaps in resonator ticks, the rest are counts
  // ----------------------------------------------------------------
  localparam int SBC_START_PULSES = 4;
  localparam int SBC_START_GAP_XT = 1024;
  localparam int SBC_STOP_GAP_XT = 65536;
  localparam int SBC_PULSE_W = 3;
  localparam int SBC_GOOD_EDGES = 2;

  // ----------------------------------------------------------------
  // Commutation
  // ----------------------------------------------------------------
  localparam int SBC_STEP_W = 3;
  localparam logic [SBC_STEP_W-1:0] SBC_STEP_FIRST = 3'h0;
  localparam logic [SBC_STEP_W-1:0] SBC_STEP_LAST = 3'h5;
  localparam int SBC_TMR_W = 28;

  localparam logic [1:0] SBC_LEAD_0 = 2'h0;
  localparam logic [1:0] SBC_LEAD_7P5 = 2'h1;
  localparam logic [1:0] SBC_LEAD_15 = 2'h2;
  localparam logic [1:0] SBC_LEAD_30 = 2'h3;

  // One-hot phase masks: bit0 U, bit1 V, bit2 W
  localparam logic [2:0] SBC_PH_U = 3'h1;
  localparam logic [2:0] SBC_PH_V = 3'h2;
  localparam logic [2:0] SBC_PH_W = 3'h4;

  typedef enum logic [2:0] {
    SBC_IDLE = 3'h1,
    SBC_FORCED = 3'h2,
    SBC_RUN = 3'h4
  } sbc_mode_t;

  // High-side phase per step in forward order U-V, U-W, V-W, V-U, W-U, W-V
  function automatic logic [2:0] sbc_hi_phase(input logic [SBC_STEP_W-1:0] step);
    case (step)
      3'h0, 3'h1: sbc_hi_phase = SBC_PH_U;
      3'h2, 3'h3: sbc_hi_phase = SBC_PH_V;
      3'h4, 3'h5: sbc_hi_phase = SBC_PH_W;
      default: sbc_hi_phase = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] sbc_lo_phase(input logic [SBC_STEP_W-1:0] step);
    case (step)
      3'h3, 3'h4: sbc_lo_phase = SBC_PH_U;
      3'h0, 3'h5: sbc_lo_phase = SBC_PH_V;
      3'h1, 3'h2: sbc_lo_phase = SBC_PH_W;
      default: sbc_lo_phase = 3'h0;
    endcase
  endfunction

  // Walking the table backwards swaps V and W in the sequence
  function automatic logic [SBC_STEP_W-1:0] sbc_next_step(
    input logic [SBC_STEP_W-1:0] step,
    input logic reverse
  );
    if (reverse) begin
      sbc_next_step = (step == SBC_STEP_FIRST) ? SBC_STEP_LAST : step - 3'h1;
    end else begin
      sbc_next_step = (step == SBC_STEP_LAST) ? SBC_STEP_FIRST : step + 3'h1;
    end
  endfunction

endpackage

// ==== core/sbc_pwm_sense.sv ====
/*
  PWM edge detection, two-edge confirmed position sampling and the
  overcurrent turn-off latch.
  Assumes all inputs are already synchronous to the core clock.
*/
`timescale 1ns/1ps

module sbc_pwm_sense
  import sbc_pkg::*;
(
  input wire logic i_core_clk,        // core clock
  input wire logic i_reset,           // async reset, active high
  input wire logic i_pwm_n,           // PWM input, low means on
  input wire logic i_wave,            // majority back-EMF position input
  input wire logic i_overcurrent_in,  // overcurrent input, high is fault
  output logic o_on_start,            // pulse: PWM on pulse begins
  output logic o_pwm_rise,            // pulse: PWM rising edge
  output logic o_pos_change,          // pulse: confirmed position change
  output logic o_oc_block             // level: chopped output held off
);

  typedef struct packed {
    logic pwm;
    logic oc;
    logic sample;
    logic pos;
    logic change;
    logic block;
  } sbc_sense_t;

  sbc_sense_t s_reg;
  sbc_sense_t s_next;
  logic rise;
  logic fall;
  logic oc_rise;

  assign rise = i_pwm_n & ~s_reg.pwm;
  assign fall = ~i_pwm_n & s_reg.pwm;
  assign oc_rise = i_overcurrent_in & ~s_reg.oc;

  always_comb begin
    s_next = s_reg;
    s_next.pwm = i_pwm_n;
    s_next.oc = i_overcurrent_in;
    s_next.change = 1'b0;
    // Position is looked at only here, so 0 % and 100 % duty see nothing
    if (rise) begin
      s_next.sample = i_wave;
      if (i_wave == s_reg.sample && i_wave != s_reg.pos) begin
        s_next.pos = i_wave;
        s_next.change = 1'b1;
      end
    end
    // Next on pulse releases the latch, but a new fault in that cycle wins
    if (fall) begin
      s_next.block = 1'b0;
    end
    if (oc_rise) begin
      s_next.block = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s_reg <= '{pwm: 1'b1, oc: 1'b1, sample: 1'b1, pos: 1'b1, change: 1'b0, block: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_on_start = fall;
  assign o_pwm_rise = rise;
  assign o_pos_change = s_reg.change;
  assign o_oc_block = s_reg.block;

endmodule

// ==== core/sbc_drive_out.sv ====
/*
  Forms the six turn-on outputs from the step, the overlap step and the
  chopping signal. High-side pins are on when low, low-side pins on when high.
  Assumes the step inputs are already registered.
*/
`timescale 1ns/1ps

module sbc_drive_out
  import sbc_pkg::*;
(
  input wire logic i_core_clk,                    // core clock
  input wire logic i_reset,                       // async reset, active high
  input wire logic i_enable,                      // drive the bridge at all
  input wire logic [SBC_STEP_W-1:0] i_step,       // current step
  input wire logic [SBC_STEP_W-1:0] i_lap_step,   // outgoing step for overlap
  input wire logic i_lap_active,                  // overlap window open
  input wire logic i_chop_on,                     // PWM on and not blocked
  input wire logic i_out_form_sel,                // 0 upper chop, 1 alternate
  output logic [2:0] o_high_side_on_n,            // per phase, low is on
  output logic [2:0] o_low_side_on                // per phase, high is on
);

  typedef struct packed {
    logic [2:0] hi_n;
    logic [2:0] lo;
  } sbc_drive_t;

  sbc_drive_t d_reg;
  sbc_drive_t d_next;
  logic [2:0] hi_act;
  logic [2:0] lo_act;
  logic chop_low;

  always_comb begin
    hi_act = sbc_hi_phase(i_step);
    lo_act = sbc_lo_phase(i_step);
    if (i_lap_active) begin
      hi_act = hi_act | sbc_hi_phase(i_lap_step);
      lo_act = lo_act | sbc_lo_phase(i_lap_step);
    end
    // Alternate form chops the low side on odd steps
    chop_low = i_out_form_sel & i_step[0];
    d_next.hi_n = 3'h7;
    d_next.lo = 3'h0;
    if (i_enable) begin
      if (chop_low) begin
        d_next.hi_n = ~hi_act;
        d_next.lo = lo_act & {3{i_chop_on}};
      end else begin
        d_next.hi_n = ~(hi_act & {3{i_chop_on}});
        d_next.lo = lo_act;
      end
    end
  end

  // Both sides start off: high-side pins high, low-side pins low
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      d_reg <= '{hi_n: 3'h7, lo: 3'h0};
    end else begin
      d_reg <= d_next;
    end
  end

  assign o_high_side_on_n = d_reg.hi_n;
  assign o_low_side_on = d_reg.lo;

endmodule

// ==== testbench/sbc_commutator_asserts.sv ====
/*
  Port checker for sbc_commutator.
  Assumes it is bound to the commutator and sees only its ports.
*/
`timescale 1ns/1ps

module sbc_commutator_asserts
  import sbc_pkg::*;
#(
  parameter int FORCED_STEP_XT = SBC_FORCED_STEP_XT,  // ticks a step
  parameter int STOP_GAP_XT = SBC_STOP_GAP_XT         // ticks to stop
)(
  input wire logic i_core_clk,          // clock
  input wire logic i_reset,             // async reset
  input wire logic i_pwm_n,             // PWM, low on
  input wire logic i_wave,              // position
  input wire logic i_overcurrent_in,    // fault
  input wire logic i_advance_sel_lo,    // lead low bit
  input wire logic i_advance_sel_hi,    // lead high bit
  input wire logic i_direction_select,  // 1 reverse
  input wire logic i_out_form_sel,      // chop form
  input wire logic i_lap_sel,           // 1 plain 120
  input wire logic o_u_high_side_on_n,  // U high
  input wire logic o_u_low_side_on,     // U low
  input wire logic o_v_high_side_on_n,  // V high
  input wire logic o_v_low_side_on,     // V low
  input wire logic o_w_high_side_on_n,  // W high
  input wire logic o_w_low_side_on,     // W low
  input wire logic o_forced,            // forced mode
  input wire logic o_running            // back-EMF mode
);
  // Stop may land up to a resonator tick either side of the gap
  localparam int STOP_MAX = (STOP_GAP_XT + 2) * SBC_XT_DIV;
  logic [2:0] hi_on;
  logic [2:0] lo_on;
  logic quiet;
  logic [31:0] off_cnt_reg;
  logic [31:0] off_cnt_next;

  assign hi_on = ~{o_w_high_side_on_n, o_v_high_side_on_n, o_u_high_side_on_n};
  assign lo_on = {o_w_low_side_on, o_v_low_side_on, o_u_low_side_on};
  assign quiet = !o_forced && !o_running;
  assign off_cnt_next = i_pwm_n ? off_cnt_reg + 32'h1 : 32'h0;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      off_cnt_reg <= 32'h0;
    end else begin
      off_cnt_reg <= off_cnt_next;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  // ----------------------------------------------------------------
  // Port rules
  // ----------------------------------------------------------------
  idle_outputs_off_a: assert property (
    quiet && $past(quiet) |-> hi_on == 3'h0 && lo_on == 3'h0) else $error("drive while idle");
  no_shoot_through_a: assert property (
    (hi_on & lo_on) == 3'h0) else $error("both sides of a phase on");
  one_high_side_a: assert property (
    i_lap_sel && $past(i_lap_sel) |-> $countones(hi_on) <= 1) else $error("two high sides");
  one_low_side_a: assert property (
    i_lap_sel && $past(i_lap_sel) |-> $countones(lo_on) <= 1) else $error("two low sides");
  pwm_gates_high_a: assert property (
    i_lap_sel && !i_out_form_sel && $past(i_pwm_n) && $past(i_pwm_n, 2)
    |-> hi_on == 3'h0) else $error("high side on while PWM off");
  alt_chop_form_a: assert property (
    i_lap_sel && i_out_form_sel && $past(i_out_form_sel) && $past(i_pwm_n) && $past(i_pwm_n, 2)
    |-> !(hi_on != 3'h0 && lo_on != 3'h0)) else $error("alternate chop not applied");
  oc_blocks_chop_a: assert property (
    $rose(i_overcurrent_in) && i_lap_sel && !i_out_form_sel |-> ##2 hi_on == 3'h0)
    else $error("overcurrent did not block chopping");
  low_side_order_a: assert property (
    i_lap_sel && $past(i_lap_sel) && !i_out_form_sel && $past(!i_out_form_sel)
    && $stable(i_direction_select) && lo_on != $past(lo_on) && lo_on != 3'h0
    && $past(lo_on) != 3'h0 |-> lo_on == (i_direction_select
    ? {$past(lo_on[0]), $past(lo_on[2:1])} : {$past(lo_on[1:0]), $past(lo_on[2])}))
    else $error("commutation order wrong");
  run_after_forced_a: assert property (
    $rose(o_running) |-> $past(o_forced)) else $error("back-EMF mode without startup");
  modes_exclusive_a: assert property (
    !(o_forced && o_running)) else $error("two modes at once");
  stop_on_zero_a: assert property (
    off_cnt_reg > STOP_MAX |-> quiet) else $error("no stop at zero duty");

  forced_start_c: cover property ($rose(o_forced));
  run_entry_c: cover property ($rose(o_running));
  oc_hit_c: cover property ($rose(i_overcurrent_in) && o_running);
endmodule

bind sbc_commutator sbc_commutator_asserts #(
  .FORCED_STEP_XT(FORCED_STEP_XT),
  .STOP_GAP_XT(STOP_GAP_XT)
) i_asserts (
  .i_core_clk, .i_reset, .i_pwm_n, .i_wave, .i_overcurrent_in, .i_advance_sel_lo,
  .i_advance_sel_hi, .i_direction_select, .i_out_form_sel, .i_lap_sel,
  .o_u_high_side_on_n, .o_u_low_side_on, .o_v_high_side_on_n, .o_v_low_side_on,
  .o_w_high_side_on_n, .o_w_low_side_on, .o_forced, .o_running
);

// ==== testbench/sbc_bridge_model.sv ====
/*
  Far side model: low-active PWM source and a rotor whose back-EMF
  position signal flips a while after each commutation step.
  Assumes drive pins are looked at on the falling clock edge.
*/
`timescale 1ns/1ps

module sbc_bridge_model
  import sbc_pkg::*;
(
  input wire logic i_core_clk,      // core clock
  input wire logic i_run,           // 0 gives zero duty
  input wire logic [7:0] i_on_len,  // on cycles a period
  input wire logic i_emf_en,        // 1 rotor turning
  input wire logic [2:0] i_hi_on,   // high sides on, bit0 U
  input wire logic [2:0] i_lo_on,   // low sides on, bit0 U
  output logic o_pwm_n,             // PWM, low on
  output logic o_wave               // position signal
);
  localparam int PERIOD = 200;
  localparam int EMF_DLY = 300;
  int ph = 0;
  int dly = 0;
  logic [5:0] key = 6'h0;
  logic [5:0] seen = 6'h0;

  initial o_pwm_n = 1'b1;
  initial o_wave = 1'b1;

  always @(negedge i_core_clk) begin
    ph = (ph == PERIOD - 1) ? 0 : ph + 1;
    // On time capped at 120 of 200, so high time never falls under 320 ns
    o_pwm_n <= !(i_run && ph < int'(i_on_len) && ph < 120);
    if (i_hi_on != 3'h0) key[5:3] = i_hi_on;
    if (i_lo_on != 3'h0) key[2:0] = i_lo_on;
    if (key != seen) begin
      seen = key;
      dly = EMF_DLY;
    end else if (dly > 0) begin
      dly = dly - 1;
    end
    // Still rotor: the open input reads high through its pull-up
    o_wave <= i_emf_en ? (o_wave ^ (dly == 1)) : 1'b1;
  end
endmodule

// ==== testbench/tb.sv ====
/*
  Self-checking bench for sbc_commutator.
  Assumes the checker is bound in and the bridge model drives PWM and position.
*/
`timescale 1ns/1ps

module tb;
  import sbc_pkg::*;
  localparam int FSTEP = 16;
  localparam int SGAP = 60;
  localparam int STEP = FSTEP * SBC_XT_DIV;
  logic core_clk, reset, ovc, lead_lo, lead_hi, dir, form, lap, run, emf, pwm_n, wave;
  logic uh_n, ul, vh_n, vl, wh_n, wl, forced, running;
  logic [7:0] on_len;
  logic [2:0] hi_on;
  logic [2:0] lo_on;
  int n_fail;
  int n_checks;
  int n;

  assign hi_on = ~{wh_n, vh_n, uh_n};
  assign lo_on = {wl, vl, ul};
  always #2 core_clk = ~core_clk;

  sbc_commutator #(.FORCED_STEP_XT(FSTEP), .STOP_GAP_XT(SGAP)) i_dut (
    .i_core_clk(core_clk), .i_reset(reset), .i_pwm_n(pwm_n), .i_wave(wave),
    .i_overcurrent_in(ovc), .i_advance_sel_lo(lead_lo), .i_advance_sel_hi(lead_hi),
    .i_direction_select(dir), .i_out_form_sel(form), .i_lap_sel(lap),
    .o_u_high_side_on_n(uh_n), .o_u_low_side_on(ul), .o_v_high_side_on_n(vh_n),
    .o_v_low_side_on(vl), .o_w_high_side_on_n(wh_n), .o_w_low_side_on(wl),
    .o_forced(forced), .o_running(running));

  sbc_bridge_model i_bridge (
    .i_core_clk(core_clk), .i_run(run), .i_on_len(on_len), .i_emf_en(emf),
    .i_hi_on(hi_on), .i_lo_on(lo_on), .o_pwm_n(pwm_n), .o_wave(wave));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Step timing is only known to one resonator tick
  function automatic logic in_tol(input int got, input int want);
    in_tol = got >= want - 70 && got <= want + 70;
  endfunction

  function automatic logic cur(input int sel);
    case (sel)
      0: cur = forced;
      1: cur = running;
      2: cur = !forced && !running;
      default: cur = $countones(lo_on) == 2 || $countones(hi_on) == 2;
    endcase
  endfunction

  task automatic wait_sig(input int sel, input int lim);
    int k;
    k = 0;
    while (cur(sel) !== 1'b1 && k < lim) begin
      @(negedge core_clk);
      k++;
    end
  endtask

  task automatic wait_pwm(input logic v);
    int k;
    k = 0;
    while (pwm_n !== v && k < 400) begin
      @(negedge core_clk);
      k++;
    end
  endtask

  task automatic wait_low_chg(output int cnt);
    logic [2:0] old;
    old = lo_on;
    cnt = 0;
    while ((lo_on === old || lo_on === 3'h0) && cnt < 3 * STEP) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask

  task automatic oc_test;
    wait_pwm(1'b1);
    wait_pwm(1'b0);
    repeat (20) @(negedge core_clk);
    check($countones(hi_on), 1, "chopped high side on");
    ovc = 1'b1;
    repeat (3) @(negedge core_clk);
    check(hi_on, 3'h0, "chop blocked");
    ovc = 1'b0;
    wait_pwm(1'b1);
    wait_pwm(1'b0);
    repeat (3) @(negedge core_clk);
    check($countones(hi_on), 1, "chop restored");
  endtask

  task automatic stop_motor;
    run = 1'b0;
    wait_sig(2, (SGAP + 4) * SBC_XT_DIV);
    repeat (2) @(negedge core_clk);
    check({hi_on, lo_on, forced, running}, 16'h0, "stopped");
  endtask

  task automatic stop_test;
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    core_clk = 1'b0;
    n_fail = 0;
    n_checks = 0;
    on_len = 8'd100;
    {reset, ovc, lead_lo, lead_hi, dir, form, lap, run, emf} = 9'h104;
    void'($urandom(32'h8d02ab39));
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    check({hi_on, lo_on, forced, running}, 16'h0, "reset state");
    // ----------------------------------------------------------------
    // Forced stepping, rotor still: lead 0 and 7.5 start at 0, then lead 30
    // ----------------------------------------------------------------
    for (int d = 0; d < 3; d++) begin
      dir = (d == 1);
      {lead_hi, lead_lo} = (d == 2) ? 2'h3 : 2'(d);
      run = 1'b1;
      wait_sig(0, 4000);
      check(forced, 1'b1, "forced start");
      repeat (10) @(negedge core_clk);
      wait_low_chg(n);
      check(lo_on, dir ? 3'h1 : 3'h4, "first low change");
      check(in_tol(n + 10, (d == 2) ? STEP / 2 : (d == 1) ? 2 * STEP : STEP),
        1'b1, "first step time");
      wait_low_chg(n);
      check(lo_on, dir ? 3'h4 : 3'h1, "second low change");
      check(in_tol(n, 2 * STEP), 1'b1, "forced rate");
      check(running, 1'b0, "no position, still forced");
      stop_motor();
    end
    // ----------------------------------------------------------------
    // Turning rotor, every lead code, random duty and direction
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      {lead_hi, lead_lo} = 2'(i);
      dir = 1'($urandom);
      form = (i < 2) ? (i == 1) : 1'($urandom);
      lap = (i < 2) ? (i == 0) : 1'($urandom);
      on_len = 8'd40 + 8'($urandom % 80);
      emf = 1'b1;
      run = 1'b1;
      wait_sig(1, 20000);
      check(running, 1'b1, "back-EMF stepping");
      if (lap && !form) oc_test();
      if (!lap) begin
        wait_sig(3, 20000);
        check(cur(3), 1'b1, "turn-on overlap");
      end
      stop_motor();
      emf = 1'b0;
    end
    stop_test();
  end
endmodule
